// ==== rtl/pic_ctrl.sv ====
`timescale 1ns/1ns
`include "pic_defs.svh"

module pic_ctrl
	import pic_pkg::*;
(
	input wire logic i_ref_clk, // System clock, 125 MHz
	input wire logic i_rst_n, // Sync reset, active low
	input wire logic [23:0] i_addr, // CPU I/O address
	input wire logic i_wr, // CPU write strobe
	input wire logic i_rd, // CPU read strobe
	input wire logic [7:0] i_wdata, // CPU write data
	output logic [7:0] o_rdata, // Read data, next cycle
	output logic o_rd_hit, // Read data valid from this block
	input wire logic [2:0] i_evt_stopw, // Stopwatch 100/10/1 Hz pulses
	input wire logic [3:0] i_evt_clktmr, // Clock timer 32/8/2/1 Hz pulses
	input wire logic [1:0] i_evt_progtmr, // Timer 1, timer 0 pulses
	input wire logic i_evt_keygrp1, // Two-key group pulse
	input wire logic [1:0] i_evt_keygrp0, // Upper, lower key half pulses
	input wire logic [2:0] i_evt_serial, // Error, receive, transmit pulses
	output logic o_irq_req, // Interrupt request level
	output pic_level_t o_irq_level, // Level of the request
	output pic_src_idx_t o_irq_src // Winning source number
);

	////////////////////////////////////////////////////////////////
	// Address decode shared by the read and write paths
	function automatic logic pic_hit(input logic [23:0] addr, input logic [23:0] target);
		pic_hit = (addr == target);
	endfunction

	logic [7:0] prio_a;
	logic [3:0] prio_b;
	logic [6:0] en_a;
	logic [7:0] en_b;
	logic [6:0] flags_a;
	logic [7:0] flags_b;
	logic bsmd_seen;
	logic spp_seen;
	pic_gate_t gate;
	logic [`PIC_NUM_SRC-1:0] pending;
	logic [2*`PIC_NUM_SRC-1:0] levels;
	logic arb_any;
	pic_level_t arb_level;
	pic_src_idx_t arb_idx;
	logic [6:0] set_a;
	logic [7:0] set_b;
	logic wr_flag_a;
	logic wr_flag_b;

	////////////////////////////////////////////////////////////////
	// Priority registers
	// keygrp0, serial, stopwatch and clock timer priority fields
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			prio_a <= `PIC_RST_PRIO_A;
		end else if (i_wr && pic_hit(i_addr, `PIC_ADDR_PRIO_A)) begin
			prio_a <= i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			prio_b <= `PIC_RST_PRIO_B;
		end else if (i_wr && pic_hit(i_addr, `PIC_ADDR_PRIO_B)) begin
			prio_b <= i_wdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Enable registers
	// stopwatch and clock timer enables
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			en_a <= `PIC_RST_EN_A;
		end else if (i_wr && pic_hit(i_addr, `PIC_ADDR_EN_A)) begin
			en_a <= i_wdata[6:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			en_b <= `PIC_RST_EN_B;
		end else if (i_wr && pic_hit(i_addr, `PIC_ADDR_EN_B)) begin
			en_b <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Event routing into the flag banks
	always_comb begin
		set_a = 7'h00;
		set_a[`PIC_STOPW_100HZ_BIT] = i_evt_stopw[2];
		set_a[`PIC_STOPW_10HZ_BIT] = i_evt_stopw[1];
		set_a[`PIC_STOPW_1HZ_BIT] = i_evt_stopw[0];
		set_a[`PIC_CLKTMR_32HZ_BIT] = i_evt_clktmr[3];
		set_a[`PIC_CLKTMR_8HZ_BIT] = i_evt_clktmr[2];
		set_a[`PIC_CLKTMR_2HZ_BIT] = i_evt_clktmr[1];
		set_a[`PIC_CLKTMR_1HZ_BIT] = i_evt_clktmr[0];
		set_b = 8'h00;
		set_b[`PIC_PROGTMR1_BIT] = i_evt_progtmr[1];
		set_b[`PIC_PROGTMR0_BIT] = i_evt_progtmr[0];
		set_b[`PIC_KEYGRP1_BIT] = i_evt_keygrp1;
		set_b[`PIC_KEYGRP0_UPPER_BIT] = i_evt_keygrp0[1];
		set_b[`PIC_KEYGRP0_LOWER_BIT] = i_evt_keygrp0[0];
		set_b[`PIC_SERIAL_ERR_BIT] = i_evt_serial[2];
		set_b[`PIC_SERIAL_RX_BIT] = i_evt_serial[1];
		set_b[`PIC_SERIAL_TX_BIT] = i_evt_serial[0];
	end

	assign wr_flag_a = i_wr && pic_hit(i_addr, `PIC_ADDR_FLAG_A);
	assign wr_flag_b = i_wr && pic_hit(i_addr, `PIC_ADDR_FLAG_B);

	pic_flag_bank #(
		.W(`PIC_NUM_SRC_A)
	) u_flags_a (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_set(set_a),
		.i_clr(wr_flag_a),
		.i_wdata(i_wdata[6:0]),
		.o_flags(flags_a)
	);

	pic_flag_bank #(
		.W(`PIC_NUM_SRC_B)
	) u_flags_b (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_set(set_b),
		.i_clr(wr_flag_b),
		.i_wdata(i_wdata),
		.o_flags(flags_b)
	);

	////////////////////////////////////////////////////////////////
	// Register read; unused bits read zero
	// upper bits read zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
			o_rd_hit <= 1'b0;
		end else begin
			o_rd_hit <= 1'b0;
			o_rdata <= 8'h00;
			if (i_rd) begin
				o_rd_hit <= 1'b1;
				if (pic_hit(i_addr, `PIC_ADDR_PRIO_A)) begin
					o_rdata <= prio_a;
				end else if (pic_hit(i_addr, `PIC_ADDR_PRIO_B)) begin
					o_rdata <= {4'h0, prio_b};
				end else if (pic_hit(i_addr, `PIC_ADDR_EN_A)) begin
					o_rdata <= {1'b0, en_a};
				end else if (pic_hit(i_addr, `PIC_ADDR_EN_B)) begin
					o_rdata <= en_b;
				end else if (pic_hit(i_addr, `PIC_ADDR_FLAG_A)) begin
					o_rdata <= {1'b0, flags_a};
				end else if (pic_hit(i_addr, `PIC_ADDR_FLAG_B)) begin
					o_rdata <= flags_b;
				end else begin
					// Not ours: other blocks answer this address
					o_rd_hit <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Watch for the two system setup writes; the registers live elsewhere
	// setup writes tracked
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			bsmd_seen <= 1'b0;
			spp_seen <= 1'b0;
		end else if (i_wr) begin
			if (pic_hit(i_addr, `PIC_ADDR_BUS_MODE)) begin
				bsmd_seen <= 1'b1;
			end
			if (pic_hit(i_addr, `PIC_ADDR_STACK_PAGE)) begin
				spp_seen <= 1'b1;
			end
		end
	end

	// Gate stays locked so a stack in an unset page is never pushed
	// gate opens after both
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			gate <= PIC_GATE_LOCKED;
		end else begin
			case (gate)
				PIC_GATE_LOCKED: begin
					if (bsmd_seen && spp_seen) begin
						gate <= PIC_GATE_OPEN;
					end
				end
				PIC_GATE_OPEN: begin
					gate <= PIC_GATE_OPEN;
				end
				default: begin
					gate <= PIC_GATE_LOCKED;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Per-source pending bits and levels, numbered A bits then B bits
	assign pending = {flags_b & en_b, flags_a & en_a};

	always_comb begin
		levels = '0;
		for (int i = 0; i < `PIC_NUM_SRC_A; i++) begin
			if (i >= `PIC_STOPW_1HZ_BIT) begin
				levels[2*i +: 2] = prio_a[`PIC_STOPW_PRIO_LSB +: 2];
			end else begin
				levels[2*i +: 2] = prio_a[`PIC_CLKTMR_PRIO_LSB +: 2];
			end
		end
		for (int j = 0; j < `PIC_NUM_SRC_B; j++) begin
			if (j >= `PIC_PROGTMR0_BIT) begin
				levels[2*(j+`PIC_NUM_SRC_A) +: 2] = prio_b[`PIC_PROGTMR_PRIO_LSB +: 2];
			end else if (j == `PIC_KEYGRP1_BIT) begin
				levels[2*(j+`PIC_NUM_SRC_A) +: 2] = prio_b[`PIC_KEYGRP1_PRIO_LSB +: 2];
			end else if (j >= `PIC_KEYGRP0_LOWER_BIT) begin
				levels[2*(j+`PIC_NUM_SRC_A) +: 2] = prio_a[`PIC_KEYGRP0_PRIO_LSB +: 2];
			end else begin
				levels[2*(j+`PIC_NUM_SRC_A) +: 2] = prio_a[`PIC_SERIAL_PRIO_LSB +: 2];
			end
		end
	end

	pic_prio_arb u_arb (
		.i_pending(pending),
		.i_levels(levels),
		.o_any(arb_any),
		.o_level(arb_level),
		.o_idx(arb_idx)
	);

	////////////////////////////////////////////////////////////////
	// Registered request toward the core; one cycle behind the flags
	// request at source level
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_irq_req <= 1'b0;
			o_irq_level <= 2'b00;
			o_irq_src <= 4'h0;
		end else begin
			o_irq_req <= arb_any && (gate == PIC_GATE_OPEN);
			o_irq_level <= arb_level;
			o_irq_src <= arb_idx;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	chk_prio_reset_zero: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> (prio_a == 8'h00 && prio_b == 4'h0)
	) else $error("priority not zero after reset");

	chk_prio_b_upper: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && pic_hit(i_addr, `PIC_ADDR_PRIO_B)) |=> (o_rd_hit && o_rdata[7:4] == 4'h0)
	) else $error("priority B upper bits not zero");

	chk_prio_a_readback: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && pic_hit(i_addr, `PIC_ADDR_PRIO_A)) ##1 (i_rd && pic_hit(i_addr, `PIC_ADDR_PRIO_A) && !i_wr)
		|=> (o_rdata == $past(i_wdata, 2))
	) else $error("priority A read back wrong");

	chk_en_a_top: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && pic_hit(i_addr, `PIC_ADDR_EN_A)) |=> (o_rdata[7] == 1'b0 && o_rdata[6:0] == $past(en_a))
	) else $error("enable A read wrong");

	chk_key_halves: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wr && pic_hit(i_addr, `PIC_ADDR_EN_B)) |=> (en_b[4:3] == $past(i_wdata[4:3]))
	) else $error("key half enables not separate");

	chk_gate_hold: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!(bsmd_seen && spp_seen) |=> !o_irq_req
	) else $error("request before setup writes");

	chk_req_follows: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(gate == PIC_GATE_OPEN && (pending != '0)) |=> (o_irq_req && o_irq_level == $past(arb_level))
	) else $error("pending source not requested");

	chk_req_cause: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_irq_req |-> $past(pending[arb_idx]) || $past(pending != '0)
	) else $error("request without pending source");

	chk_flag_a_top: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && pic_hit(i_addr, `PIC_ADDR_FLAG_A)) |=> (o_rdata[7] == 1'b0)
	) else $error("flag A bit 7 not zero");

endmodule

// ==== shared/pic_defs.svh ====
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// Register byte addresses in the CPU I/O space
`define PIC_ADDR_BUS_MODE 24'h00FF00
`define PIC_ADDR_STACK_PAGE 24'h00FF01
`define PIC_ADDR_PRIO_A 24'h00FF20
`define PIC_ADDR_PRIO_B 24'h00FF21
`define PIC_ADDR_EN_A 24'h00FF22
`define PIC_ADDR_EN_B 24'h00FF23
`define PIC_ADDR_FLAG_A 24'h00FF24
`define PIC_ADDR_FLAG_B 24'h00FF25

// Reset values
`define PIC_RST_PRIO_A 8'h00
`define PIC_RST_PRIO_B 4'h0
`define PIC_RST_EN_A 7'h00
`define PIC_RST_EN_B 8'h00

// Priority field positions (two bits each, low bit given)
`define PIC_KEYGRP0_PRIO_LSB 6
`define PIC_SERIAL_PRIO_LSB 4
`define PIC_STOPW_PRIO_LSB 2
`define PIC_CLKTMR_PRIO_LSB 0
`define PIC_PROGTMR_PRIO_LSB 2
`define PIC_KEYGRP1_PRIO_LSB 0

// Enable and flag bit positions, register A
`define PIC_STOPW_100HZ_BIT 6
`define PIC_STOPW_10HZ_BIT 5
`define PIC_STOPW_1HZ_BIT 4
`define PIC_CLKTMR_32HZ_BIT 3
`define PIC_CLKTMR_8HZ_BIT 2
`define PIC_CLKTMR_2HZ_BIT 1
`define PIC_CLKTMR_1HZ_BIT 0

// Enable and flag bit positions, register B
`define PIC_PROGTMR1_BIT 7
`define PIC_PROGTMR0_BIT 6
`define PIC_KEYGRP1_BIT 5
`define PIC_KEYGRP0_UPPER_BIT 4
`define PIC_KEYGRP0_LOWER_BIT 3
`define PIC_SERIAL_ERR_BIT 2
`define PIC_SERIAL_RX_BIT 1
`define PIC_SERIAL_TX_BIT 0

// Source numbering: A bits first, then B bits
`define PIC_NUM_SRC_A 7
`define PIC_NUM_SRC_B 8
`define PIC_NUM_SRC 15

`endif

// ==== shared/pic_pkg.sv ====
package pic_pkg;

	typedef logic [1:0] pic_level_t;
	typedef logic [3:0] pic_src_idx_t;

	// Interrupt gate after reset
	typedef enum logic [0:0] {
		PIC_GATE_LOCKED,
		PIC_GATE_OPEN
	} pic_gate_t;

endpackage

// ==== rtl/pic_flag_bank.sv ====
`timescale 1ns/1ns
`include "pic_defs.svh"

module pic_flag_bank
	import pic_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst_n, // Sync reset, active low
	input wire logic [W-1:0] i_set, // Event pulses
	input wire logic i_clr, // Write strobe to this register
	input wire logic [W-1:0] i_wdata, // Ones clear matching flags
	output logic [W-1:0] o_flags // Sticky flags
);

	////////////////////////////////////////////////////////////////
	// One sticky flag per bit; set beats a same-cycle clear so no event is lost
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_flag
			always_ff @(posedge i_ref_clk) begin
				if (!i_rst_n) begin
					o_flags[g] <= 1'b0;
				end else if (i_set[g]) begin
					o_flags[g] <= 1'b1;
				end else if (i_clr && i_wdata[g]) begin
					o_flags[g] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Checks
	chk_flag_w1c_clear: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clr && ((i_wdata & ~i_set) != '0)) |=> ((o_flags & $past(i_wdata & ~i_set)) == '0)
	) else $error("flag not cleared by write of one");

	chk_flag_set_wins: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_set != '0) |=> ((o_flags & $past(i_set)) == $past(i_set))
	) else $error("event did not set its flag");

	chk_flag_zero_keeps: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clr && i_set == '0) |=> ((o_flags & ~$past(i_wdata)) == ($past(o_flags) & ~$past(i_wdata)))
	) else $error("writing zero changed a flag");

endmodule

// ==== rtl/pic_prio_arb.sv ====
`timescale 1ns/1ns
`include "pic_defs.svh"

module pic_prio_arb
	import pic_pkg::*;
(
	input wire logic [`PIC_NUM_SRC-1:0] i_pending, // Flag and enable per source
	input wire logic [2*`PIC_NUM_SRC-1:0] i_levels, // Level per source
	output logic o_any, // Some source pending
	output pic_level_t o_level, // Highest pending level
	output pic_src_idx_t o_idx // Winning source
);

	////////////////////////////////////////////////////////////////
	// Highest level wins; on a tie the lower source number wins
	// highest level selected
	always_comb begin
		o_any = 1'b0;
		o_level = 2'b00;
		o_idx = 4'h0;
		for (int i = 0; i < `PIC_NUM_SRC; i++) begin
			if (i_pending[i] && (!o_any || i_levels[2*i +: 2] > o_level)) begin
				o_any = 1'b1;
				o_level = i_levels[2*i +: 2];
				o_idx = 4'(i);
			end
		end
	end

endmodule

// ==== testbench/pic_evt_model.sv ====
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////
// Peripheral event sources, each a one-cycle pulse on command
module pic_evt_model (
	input wire logic i_ref_clk, // System clock
	output logic [2:0] o_stopw, // Stopwatch pulses
	output logic [3:0] o_clktmr, // Clock timer pulses
	output logic [1:0] o_progtmr, // Timer 1, timer 0 pulses
	output logic o_keygrp1, // Two-key group pulse
	output logic [1:0] o_keygrp0, // Upper, lower key pulses
	output logic [2:0] o_serial // Error, receive, transmit pulses
);
	// Quiet until told, so no stray flag is set
	initial begin
		{o_progtmr, o_keygrp1, o_keygrp0, o_serial, o_stopw, o_clktmr} = 15'h0000;
	end

	// Mask bit n is source number n; driven off the sampling edge
	task automatic fire(input logic [14:0] m);
		@(negedge i_ref_clk);
		{o_progtmr, o_keygrp1, o_keygrp0, o_serial, o_stopw, o_clktmr} = m;
		@(negedge i_ref_clk);
		{o_progtmr, o_keygrp1, o_keygrp0, o_serial, o_stopw, o_clktmr} = 15'h0000;
	endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`include "pic_defs.svh"

////////////////////////////////////////////////////////////////
// Self-checking bench for the interrupt control block
module tb
	import pic_pkg::*;
;
	typedef struct packed {logic [23:0] a; logic [7:0] d; logic [7:0] e; logic h;} pic_row_t;
	logic i_ref_clk = 1'h0;
	logic i_rst_n = 1'h0;
	logic [23:0] i_addr = 24'h000000;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_rd_hit;
	logic o_irq_req;
	pic_level_t o_irq_level;
	pic_src_idx_t o_irq_src;
	logic [2:0] ev_sw;
	logic [3:0] ev_ct;
	logic [1:0] ev_pt;
	logic ev_k1;
	logic [1:0] ev_k0;
	logic [2:0] ev_se;
	int fails = 0;
	int checks = 0;
	// Expected state kept by the bench itself
	logic [7:0] pa;
	logic [7:0] pb;
	logic [14:0] ee;
	logic [14:0] ef;
	logic g0;
	logic g1;
	// Write, then read back: address, data, expected, hit
	pic_row_t rows [11] = '{
		'{24'h00FF20, 8'h9C, 8'h9C, 1'h1}, '{24'h00FF21, 8'hFF, 8'h0F, 1'h1},
		'{24'h00FF21, 8'h06, 8'h06, 1'h1}, '{24'h00FF22, 8'hFF, 8'h7F, 1'h1},
		'{24'h00FF22, 8'h00, 8'h00, 1'h1}, '{24'h00FF23, 8'hA5, 8'hA5, 1'h1},
		'{24'h00FF23, 8'h00, 8'h00, 1'h1}, '{24'h00FF24, 8'hFF, 8'h00, 1'h1},
		'{24'h00FF25, 8'hFF, 8'h00, 1'h1}, '{24'h00FF26, 8'hFF, 8'h00, 1'h0},
		'{24'h00FF1F, 8'hFF, 8'h00, 1'h0}};

	// 125 MHz clock
	always #4 i_ref_clk = ~i_ref_clk;

	pic_ctrl i_pic_ctrl (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
		.i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit), .i_evt_stopw(ev_sw),
		.i_evt_clktmr(ev_ct), .i_evt_progtmr(ev_pt), .i_evt_keygrp1(ev_k1), .i_evt_keygrp0(ev_k0),
		.i_evt_serial(ev_se), .o_irq_req(o_irq_req), .o_irq_level(o_irq_level), .o_irq_src(o_irq_src));
	pic_evt_model i_pic_evt_model (.i_ref_clk(i_ref_clk), .o_stopw(ev_sw), .o_clktmr(ev_ct),
		.o_progtmr(ev_pt), .o_keygrp1(ev_k1), .o_keygrp0(ev_k0), .o_serial(ev_se));

	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One write; the expected state follows it
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_wr = 1'h1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_ref_clk);
		i_wr = 1'h0;
		case (a)
			24'h00FF20: pa = d;
			24'h00FF21: pb = {4'h0, d[3:0]};
			24'h00FF22: ee[6:0] = d[6:0];
			24'h00FF23: ee[14:7] = d;
			24'h00FF24: ef[6:0] = ef[6:0] & ~d[6:0];
			24'h00FF25: ef[14:7] = ef[14:7] & ~d;
			24'h00FF00: g0 = 1'h1;
			24'h00FF01: g1 = 1'h1;
			default: ;
		endcase
	endtask

	// One read; data and hit stand for the cycle after the strobe
	task automatic rd(input logic [23:0] a, input logic [7:0] e, input logic h);
		@(negedge i_ref_clk);
		i_rd = 1'h1;
		i_addr = a;
		@(negedge i_ref_clk);
		i_rd = 1'h0;
		chk(o_rdata, e, "read data");
		chk({7'h00, o_rd_hit}, {7'h00, h}, "read hit");
	endtask

	task automatic fire(input logic [14:0] m);
		i_pic_evt_model.fire(m);
		ef = ef | m;
	endtask

	// Level of source i from the expected priority registers
	function automatic logic [1:0] lvl(input int i);
		if (i < 4) return pa[1:0];
		if (i < 7) return pa[3:2];
		if (i < 10) return pa[5:4];
		if (i < 12) return pa[7:6];
		if (i == 12) return pb[1:0];
		return pb[3:2];
	endfunction

	// Highest level wins, lower number on a tie; -1 when nothing may request
	function automatic int win();
		int w;
		w = -1;
		for (int i = 0; i < 15; i++) begin
			if (ef[i] && ee[i] && (w < 0 || lvl(i) > lvl(w))) w = i;
		end
		if (!(g0 && g1)) w = -1;
		return w;
	endfunction

	task automatic chk_irq();
		int w;
		repeat (3) @(negedge i_ref_clk);
		w = win();
		if (w < 0) chk({7'h00, o_irq_req}, 8'h00, "request idle");
		else chk({1'h1, o_irq_req, o_irq_level, o_irq_src}, {2'h3, lvl(w), w[3:0]}, "request");
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int w;
		pa = 8'h00;
		pb = 8'h00;
		ee = 15'h0000;
		ef = 15'h0000;
		g0 = 1'h0;
		g1 = 1'h0;
		repeat (12) @(negedge i_ref_clk);
		i_rst_n = 1'h1;
		for (int i = 0; i < 6; i++) rd(24'h00FF20 + 24'(i), 8'h00, 1'h1); // Zero
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, rows[i].h); // Fields
		end
		$display("test table done");
		// Gate held shut until both bus-mode and stack-page are written
		wr(24'h00FF23, 8'h02);
		fire(15'h0101);
		rd(24'h00FF24, 8'h01, 1'h1); // Polled
		rd(24'h00FF25, 8'h02, 1'h1); // Flag
		chk_irq(); // Shut
		wr(24'h00FF00, 8'h00);
		chk_irq(); // Shut
		wr(24'h00FF01, 8'h00);
		chk_irq(); // Open
		$display("test gate done");
		// Each enable bit gates only its own source
		fire(15'h7FFF);
		for (int i = 0; i < 15; i++) begin
			wr(24'h00FF22, i < 7 ? 8'h01 << i : 8'h00);
			wr(24'h00FF23, i < 7 ? 8'h00 : 8'h01 << (i - 7));
			chk_irq(); // Enable
		end
		$display("test enables done");
		// Two priority settings; clear the winner each time
		for (int p = 0; p < 2; p++) begin
			wr(24'h00FF20, p ? 8'h63 : 8'h9C);
			wr(24'h00FF21, p ? 8'h0D : 8'h06);
			wr(24'h00FF22, 8'h7F);
			wr(24'h00FF23, 8'hFF);
			fire(15'h7FFF);
			rd(24'h00FF24, 8'h7F, 1'h1); // All
			rd(24'h00FF25, 8'hFF, 1'h1); // All
			chk_irq(); // Winner
			for (int k = 0; k < 15; k++) begin
				w = win();
				wr(w < 7 ? 24'h00FF24 : 24'h00FF25, w < 7 ? 8'h01 << w : 8'h01 << (w - 7));
				chk_irq(); // Winner
			end
			rd(24'h00FF25, 8'h00, 1'h1); // Cleared
		end
		$display("test priority done");
		// Event beats a clearing write in the same cycle; a zero write keeps flags
		fork
			wr(24'h00FF25, 8'h02);
			i_pic_evt_model.fire(15'h0100);
		join
		ef[8] = 1'h1;
		rd(24'h00FF25, 8'h02, 1'h1); // Set wins
		wr(24'h00FF25, 8'h00);
		rd(24'h00FF25, 8'h02, 1'h1); // Kept
		chk_irq(); // Pending
		$display("test race done");
		// Write then read priority A with no idle cycle between them
		@(negedge i_ref_clk);
		i_wr = 1'h1;
		i_addr = 24'h00FF20;
		i_wdata = 8'h5A;
		@(negedge i_ref_clk);
		i_wr = 1'h0;
		i_rd = 1'h1;
		@(negedge i_ref_clk);
		i_rd = 1'h0;
		pa = 8'h5A;
		chk(o_rdata, 8'h5A, "back-to-back read"); // Readback
		$display("test back-to-back done");
		// Second reset in mid-run relocks the gate
		@(negedge i_ref_clk);
		i_rst_n = 1'h0;
		repeat (3) @(negedge i_ref_clk);
		i_rst_n = 1'h1;
		pa = 8'h00;
		pb = 8'h00;
		ee = 15'h0000;
		ef = 15'h0000;
		g0 = 1'h0;
		g1 = 1'h0;
		for (int i = 0; i < 6; i++) rd(24'h00FF20 + 24'(i), 8'h00, 1'h1); // Zero
		fire(15'h7FFF);
		wr(24'h00FF22, 8'h7F);
		chk_irq(); // Relocked
		$display("test second reset done");
		print_verdict();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
